// ===== rtl/spd_pkg.sv
// constants shared by the eeprom command slave, its bus master and the testbench
// assumes a single 200 MHz system clock on both ends
package spd_pkg;
	localparam int CLK_HZ        = 200_000_000;
	localparam int CLK_NS        = 5;
	// internal programming time of one write cycle, longest
	localparam int WRITE_TIME_NS = 5_000_000;
	localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_NS;
	// serial clock made by the master
	localparam int SCL_HZ        = 100_000;
	localparam int SCL_QUARTER   = CLK_HZ / (4 * SCL_HZ);

	localparam logic [3:0] TYPE_MEM  = 4'ha;
	localparam logic [3:0] TYPE_PROT = 4'h6;
	// select bits 3..1 of the protection / page commands
	localparam logic [2:0] SEL_BLK0 = 3'h1;
	localparam logic [2:0] SEL_BLK1 = 3'h4;
	localparam logic [2:0] SEL_BLK2 = 3'h5;
	localparam logic [2:0] SEL_BLK3 = 3'h0;
	localparam logic [2:0] SEL_CLR  = 3'h3;
	localparam logic [2:0] SEL_SPA0 = 3'h6;
	localparam logic [2:0] SEL_SPA1 = 3'h7;
	localparam logic [2:0] SEL_RPA  = 3'h6;
	localparam int PAGE_BYTES = 16;

	// master register map, byte addresses
	localparam logic [3:0] REG_CMD  = 4'h0;
	localparam logic [3:0] REG_TX   = 4'h4;
	localparam logic [3:0] REG_RX   = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hc;
	// command register bits
	localparam int CMD_START = 0;
	localparam int CMD_WRITE = 1;
	localparam int CMD_READ  = 2;
	localparam int CMD_STOP  = 3;
	localparam int CMD_NACK  = 4;
	localparam int CMD_W     = 5;
	// status register bits
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;

	typedef enum logic [1:0] {OP_NONE, OP_SET, OP_CLR} prot_op_t;
endpackage

// ===== rtl/spd_i2c_if.sv
// two-wire link between the bus master and the eeprom command slave
// scl is driven by the master only; sda is open drain, enables active low
`timescale 1ns/100ps
interface spd_i2c_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	logic sda;

	// wired-and with pull-up
	assign sda = !((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o));

	modport host (output scl, output sda_m_o, output sda_m_oe_n, input sda);
	modport dev  (input scl, input sda, output sda_s_o, output sda_s_oe_n);
endinterface

// ===== rtl/spd_eeprom_slave.sv
// serial command slave of a 512-byte presence-detect eeprom with block protection
// assumes the link through spd_i2c_if.dev, pins sampled on clk_sys, sync reset
// Notes on behaviour
// R1: select byte arrives msb first
// R2: 1010 selects memory, 0110 selects protection/page
// R3: memory select matches pins on bits 3..1
// R4: protect set/clear need write and high voltage
// R5: protect status reads use block codes, read
// R6: page select 110/111 steers later memory access
// R7: page read acks on page zero only
// R8: other protection-type encodings get no acknowledge
// R9: write select then acked address then data
// R10: stop right after data ack starts programming
// R11: busy programming ignores all bus activity
// R12: counter advances per written byte unless protected
// R13: protected byte nacked, memory untouched
// R14: up to sixteen bytes programmed together
// R15: master keeps within sixteen-byte page
// R16: polling select nacked while busy, acked after
// R17: reads ignore write protection
// R18: counter advances after each byte read
// R19: random read is dummy write then read
// R20: current read uses counter, then increments
// R21: blocks are page halves of 128 bytes
// R22: status data ack means block unprotected
// R23: reset clears page and protection
// R24: high voltage is its own qualifying input
`timescale 1ns/100ps
module spd_eeprom_slave #(
	parameter int WRITE_CYCLES = spd_pkg::WRITE_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	spd_i2c_if.dev          link,
	input  wire logic [2:0] select_pins,
	input  wire logic       select_pin_0_hv,
	output logic            write_busy
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_SEL, ST_ADDR, ST_WDATA, ST_RDATA, ST_PROT, ST_STAT
	} state_t;
	localparam int WCW = $clog2(WRITE_CYCLES + 1);

	logic [5:0]              s1_q, s2_q, s3_q, flt_q;
	logic                    scl_p_q, sda_p_q;
	state_t                  state_q;
	logic [3:0]              bit_q;
	logic [7:0]              sh_q;
	logic [7:0]              cnt_q;
	logic                    oe_n_q;
	logic                    arm_q, seen_q, stat_ok_q, page_q;
	spd_pkg::prot_op_t       op_q, sel_op;
	logic [1:0]              blk_q;
	logic [3:0]              prot_q;
	logic [7:0]              buf_q [spd_pkg::PAGE_BYTES];
	logic [15:0]             val_q;
	logic [7:0]              mem [512];
	logic                    busy_q;
	logic [WCW-1:0]          wcnt_q;
	logic [3:0]              idx_q;
	logic                    drain_q, dack_q;
	logic                    scl, sda, hv, scl_rise, scl_fall, start, stop, go;
	logic [2:0]              logical_select_address, dec;
	logic                    sel_ack;
	state_t                  sel_nxt;
	logic [7:0]              rd_byte;

	// scl, sda and straps: three stages, a change counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_q  <= 6'h03;
			s2_q  <= 6'h03;
			s3_q  <= 6'h03;
			flt_q <= 6'h03;
		end else begin
			s1_q  <= {select_pin_0_hv, select_pins, link.scl, link.sda};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			flt_q <= (s2_q & ~(s2_q ^ s3_q)) | (flt_q & (s2_q ^ s3_q));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= flt_q[1];
			sda_p_q <= flt_q[0];
		end
	end

	assign scl      = flt_q[1];
	assign sda      = flt_q[0];
	assign logical_select_address      = flt_q[4:2];
	assign hv       = flt_q[5]; // see R24
	assign scl_rise = scl && !scl_p_q;
	assign scl_fall = !scl && scl_p_q;
	assign start    = scl && scl_p_q && sda_p_q && !sda;
	assign stop     = scl && scl_p_q && !sda_p_q && sda;
	// only a stop in the slot right after an acked data byte programs
	assign go       = stop && arm_q && (bit_q == 4'h1) && !busy_q; // see R10
	assign rd_byte  = mem[{page_q, cnt_q}]; // see R17

	// block codes are not binary: {valid, block}
	always_comb begin
		case (sh_q[3:1])
			spd_pkg::SEL_BLK0: dec = 3'h4;
			spd_pkg::SEL_BLK1: dec = 3'h5;
			spd_pkg::SEL_BLK2: dec = 3'h6;
			spd_pkg::SEL_BLK3: dec = 3'h7;
			default:           dec = 3'h0;
		endcase
	end

	always_comb begin
		sel_ack = 1'b0;
		sel_nxt = ST_IDLE;
		sel_op  = spd_pkg::OP_NONE;
		if (sh_q[7:4] == spd_pkg::TYPE_MEM && sh_q[3:1] == logical_select_address) begin // see R2 R3
			sel_ack = 1'b1;
			sel_nxt = sh_q[0] ? ST_RDATA : ST_ADDR;
		end else if (sh_q[7:4] == spd_pkg::TYPE_PROT) begin
			if (!sh_q[0]) begin
				if (dec[2] && hv && !prot_q[dec[1:0]]) begin // see R4
					sel_ack = 1'b1;
					sel_nxt = ST_PROT;
					sel_op  = spd_pkg::OP_SET;
				end else if (sh_q[3:1] == spd_pkg::SEL_CLR && hv) begin // see R4 R24
					sel_ack = 1'b1;
					sel_nxt = ST_PROT;
					sel_op  = spd_pkg::OP_CLR;
				end else if (sh_q[3:1] == spd_pkg::SEL_SPA0 ||
				             sh_q[3:1] == spd_pkg::SEL_SPA1) begin // see R6
					sel_ack = 1'b1;
					sel_nxt = ST_PROT;
				end
			end else if (dec[2]) begin // see R5
				sel_ack = !prot_q[dec[1:0]];
				sel_nxt = ST_STAT;
			end else if (sh_q[3:1] == spd_pkg::SEL_RPA) begin // see R7
				sel_ack = !page_q;
				sel_nxt = ST_STAT;
			end
			// anything else stays unacknowledged, see R8
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q   <= ST_IDLE;
			bit_q     <= 4'h0;
			sh_q      <= 8'h00;
			cnt_q     <= 8'h00;
			oe_n_q    <= 1'b1;
			arm_q     <= 1'b0;
			seen_q    <= 1'b0;
			dack_q    <= 1'b0;
			stat_ok_q <= 1'b0;
			page_q    <= 1'b0; // see R23
			op_q      <= spd_pkg::OP_NONE;
			blk_q     <= 2'h0;
			val_q     <= 16'h0000;
		end else if (busy_q) begin // see R11 R16
			state_q <= ST_IDLE;
			oe_n_q  <= 1'b1;
			arm_q   <= 1'b0;
		end else if (start) begin
			state_q <= ST_SEL;
			bit_q   <= 4'h0;
			oe_n_q  <= 1'b1;
			arm_q   <= 1'b0;
			val_q   <= 16'h0000;
		end else if (stop) begin
			state_q <= ST_IDLE;
			oe_n_q  <= 1'b1;
			arm_q   <= 1'b0;
		end else if (state_q != ST_IDLE) begin
			if (scl_rise) begin
				if (bit_q < 4'h8)
					sh_q <= {sh_q[6:0], sda}; // see R1
				bit_q <= bit_q + 4'h1;
				if (bit_q != 4'h0)
					arm_q <= 1'b0;
				// master nack after a data byte ends the read
				if (bit_q == 4'h8 && state_q == ST_RDATA && sda)
					state_q <= ST_IDLE; // see R19 R20
			end else if (scl_fall) begin
				if (bit_q == 4'h8) begin
					// only an acked data byte may arm the write, never a select or address
					dack_q <= 1'b0;
					case (state_q)
						ST_SEL: begin
							state_q   <= sel_nxt;
							oe_n_q    <= !sel_ack;
							op_q      <= sel_op;
							blk_q     <= dec[1:0];
							stat_ok_q <= sel_ack;
							seen_q    <= 1'b0;
							if (sel_ack && !sh_q[0] && sh_q[7:4] == spd_pkg::TYPE_PROT &&
							    sh_q[3:2] == 2'h3)
								page_q <= sh_q[1]; // see R6
						end
						ST_ADDR: begin // see R9
							cnt_q   <= sh_q;
							oe_n_q  <= 1'b0;
							state_q <= ST_WDATA;
						end
						ST_WDATA: begin
							if (prot_q[{page_q, cnt_q[7]}]) begin // see R21
								oe_n_q <= 1'b1; // see R13
							end else begin
								oe_n_q             <= 1'b0;
								dack_q             <= 1'b1; // see R10
								buf_q[cnt_q[3:0]]  <= sh_q; // see R14
								val_q[cnt_q[3:0]]  <= 1'b1;
								// wraps inside the sixteen-byte page
								cnt_q[3:0]         <= cnt_q[3:0] + 4'h1; // see R12 R15
							end
						end
						ST_PROT: begin
							oe_n_q <= 1'b0;
							seen_q <= 1'b1;
							// second byte after the select is the data byte; page select never programs
							dack_q <= seen_q && op_q != spd_pkg::OP_NONE; // see R10
						end
						ST_STAT: oe_n_q <= !stat_ok_q; // see R22
						default: oe_n_q <= 1'b1;
					endcase
				end else if (bit_q == 4'h9) begin
					bit_q  <= 4'h0;
					arm_q  <= !oe_n_q && dack_q; // see R10
					if (state_q == ST_RDATA) begin
						sh_q   <= rd_byte;
						oe_n_q <= rd_byte[7];
						cnt_q  <= cnt_q + 8'h01; // see R18 R20
					end else begin
						oe_n_q <= 1'b1;
					end
				end else if (state_q == ST_RDATA) begin
					oe_n_q <= sh_q[7];
				end
			end
		end
	end

	// write cycle: protection takes effect at once, page bytes drain one per clock
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_q <= 1'b0;
			wcnt_q <= '0;
			idx_q  <= 4'h0;
			// the protection bits are not modelled as nonvolatile, so protection restarts clear; the array has no reset
			prot_q <= 4'h0;
		end else if (go) begin
			busy_q <= 1'b1;
			wcnt_q <= WCW'(WRITE_CYCLES - 1);
			idx_q  <= 4'h0;
			if (op_q == spd_pkg::OP_SET)
				prot_q[blk_q] <= 1'b1; // see R4
			else if (op_q == spd_pkg::OP_CLR)
				prot_q <= 4'h0;
		end else if (busy_q) begin
			idx_q  <= idx_q + 4'h1;
			wcnt_q <= wcnt_q - WCW'(1);
			if (wcnt_q == '0)
				busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (busy_q && drain_q && val_q[idx_q])
			mem[{page_q, cnt_q[7:4], idx_q}] <= buf_q[idx_q]; // see R14
	end

	// one pass over the buffer only
	always_ff @(posedge clk_sys) begin
		if (rst)
			drain_q <= 1'b0;
		else if (go)
			drain_q <= 1'b1;
		else if (idx_q == 4'hf)
			drain_q <= 1'b0;
	end

	assign write_busy      = busy_q;
	assign link.sda_s_oe_n = oe_n_q;
	assign link.sda_s_o    = 1'b0;
endmodule

// ===== rtl/spd_i2c_host.sv
// two-wire bus master with an avalon-mm register port
// assumes the link through spd_i2c_if.host; sda is sampled through three stages
`timescale 1ns/100ps
module spd_i2c_host #(
	parameter int QUARTER = spd_pkg::SCL_QUARTER
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	spd_i2c_if.host          link
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} hstate_t;
	localparam int QW = $clog2(QUARTER + 1);

	hstate_t                  state_q;
	logic [spd_pkg::CMD_W-1:0] pend_q;
	logic [QW-1:0]            div_q;
	logic [1:0]               ph_q;
	logic [3:0]               bit_q;
	logic [7:0]               sh_q, tx_q, rx_q;
	logic                     rd_q, nack_q, scl_q, oe_n_q, wait_q;
	logic [31:0]              rdata_q;
	logic                     s1_q, s2_q, s3_q, sda_q;
	logic                     busy, take, cmd_take;

	assign busy     = state_q != H_IDLE || |pend_q[spd_pkg::CMD_STOP:spd_pkg::CMD_START];
	assign take     = (read || write) && !wait_q;
	assign cmd_take = take && write && address == spd_pkg::REG_CMD && !busy;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			s1_q  <= link.sda;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			if (s2_q == s3_q)
				sda_q <= s2_q;
		end
	end

	// every access answers one cycle after it is presented
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
			tx_q    <= 8'h00;
		end else begin
			wait_q <= !((read || write) && wait_q);
			if (read && wait_q) begin
				if (address == spd_pkg::REG_TX)
					rdata_q <= {24'h00_0000, tx_q};
				else if (address == spd_pkg::REG_RX)
					rdata_q <= {24'h00_0000, rx_q};
				else if (address == spd_pkg::REG_STAT)
					rdata_q <= {30'h0000_0000, nack_q, busy};
				else
					rdata_q <= 32'h0000_0000;
			end
			if (take && write && address == spd_pkg::REG_TX && !busy)
				tx_q <= writedata[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= H_IDLE;
			pend_q  <= '0;
			div_q   <= '0;
			ph_q    <= 2'h0;
			bit_q   <= 4'h0;
			sh_q    <= 8'h00;
			rx_q    <= 8'h00;
			rd_q    <= 1'b0;
			nack_q  <= 1'b0;
			scl_q   <= 1'b1;
			oe_n_q  <= 1'b1;
		end else if (state_q == H_IDLE) begin
			div_q <= '0;
			ph_q  <= 2'h0;
			bit_q <= 4'h0;
			// start, then one byte, then stop, in that order
			if (pend_q[spd_pkg::CMD_START]) begin
				state_q                    <= H_START;
				pend_q[spd_pkg::CMD_START] <= 1'b0;
			end else if (pend_q[spd_pkg::CMD_WRITE] || pend_q[spd_pkg::CMD_READ]) begin
				state_q                    <= H_BYTE;
				rd_q                       <= pend_q[spd_pkg::CMD_READ];
				sh_q                       <= tx_q;
				pend_q[spd_pkg::CMD_WRITE] <= 1'b0;
				pend_q[spd_pkg::CMD_READ]  <= 1'b0;
			end else if (pend_q[spd_pkg::CMD_STOP]) begin
				state_q                   <= H_STOP;
				pend_q[spd_pkg::CMD_STOP] <= 1'b0;
			end else if (cmd_take) begin
				pend_q <= writedata[spd_pkg::CMD_W-1:0];
			end
		end else if (div_q == QW'(QUARTER - 1)) begin
			div_q <= '0;
			ph_q  <= ph_q + 2'h1;
			case (ph_q)
				2'h0: scl_q <= 1'b0;
				2'h1: begin
					if (state_q == H_START)
						oe_n_q <= 1'b1;
					else if (state_q == H_STOP)
						oe_n_q <= 1'b0;
					else if (bit_q < 4'h8)
						oe_n_q <= rd_q || sh_q[7]; // see R1
					else
						oe_n_q <= !rd_q || pend_q[spd_pkg::CMD_NACK]; // see R19 R20
				end
				2'h2: scl_q <= 1'b1;
				default: begin
					if (state_q == H_START)
						oe_n_q <= 1'b0;
					else if (state_q == H_STOP)
						oe_n_q <= 1'b1; // see R10
					else if (bit_q < 4'h8)
						sh_q <= {sh_q[6:0], sda_q};
					else if (rd_q)
						rx_q <= sh_q;
					else
						nack_q <= sda_q; // see R16
					if (state_q != H_BYTE || bit_q == 4'h8)
						state_q <= H_IDLE;
					else
						bit_q <= bit_q + 4'h1;
				end
			endcase
		end else begin
			div_q <= div_q + QW'(1);
		end
	end

	assign readdata        = rdata_q;
	assign waitrequest     = wait_q;
	assign link.scl        = scl_q;
	assign link.sda_m_oe_n = oe_n_q;
	assign link.sda_m_o    = 1'b0;
endmodule

// ===== dv/spd_eeprom_slave_properties.sv
// link and busy-flag assertions for the eeprom command slave
// assumes it sits beside the spd_i2c_if that joins the host and the slave
`timescale 1ns/100ps
module spd_eeprom_slave_properties #(
	parameter int WRITE_CYCLES = spd_pkg::WRITE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe_n,
	input wire logic write_busy
);
	logic       scl_q;
	logic       sda_q;
	logic [7:0] bits_q;
	logic [7:0] stop_age_q;
	int         busy_cnt_q;
	wire        start_w = scl && scl_q && sda_q && !sda;
	wire        stop_w  = scl && scl_q && !sda_q && sda;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence start_ev;
		start_w;
	endsequence
	sequence slave_holds;
		!sda_s_oe_n [*8];
	endsequence

	always_ff @(posedge clk_sys) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// scl rises since the last start
	always_ff @(posedge clk_sys) begin
		if (rst || start_w) begin
			bits_q <= 8'h00;
		end else if (scl && !scl_q && bits_q != 8'hff) begin
			bits_q <= bits_q + 8'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stop_age_q <= 8'hff;
		end else if (stop_w) begin
			stop_age_q <= 8'h00;
		end else if (stop_age_q != 8'hff) begin
			stop_age_q <= stop_age_q + 8'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst || !write_busy) begin
			busy_cnt_q <= 0;
		end else begin
			busy_cnt_q <= busy_cnt_q + 1;
		end
	end

	a_busy_quiet_bus: assert property (write_busy |-> sda_s_oe_n)
		else $error("slave drives sda while programming");
	a_edge_scl_low: assert property ($changed(sda_s_oe_n) |-> !scl)
		else $error("slave sda changed while scl high");
	a_start_then_quiet: assert property (start_ev |-> sda_s_oe_n [*8])
		else $error("slave drives sda right after start");
	a_ack_slot_late: assert property ($fell(sda_s_oe_n) |-> bits_q >= 8'h08)
		else $error("slave drives sda before the ninth bit");
	a_drive_holds: assert property ($fell(sda_s_oe_n) |-> slave_holds)
		else $error("slave drive too short");
	a_busy_after_stop: assert property ($rose(write_busy) |-> stop_age_q <= 8'h0c)
		else $error("write cycle without a stop");
	a_busy_length: assert property ($fell(write_busy) |-> busy_cnt_q == WRITE_CYCLES)
		else $error("write cycle length wrong");
	a_reset_idle_out: assert property (disable iff (1'b0)
		$fell(rst) |-> sda_s_oe_n && !write_busy)
		else $error("slave not idle after reset");
endmodule

// ===== dv/spd_eeprom_serial_command_slave_tb.sv
// self-checking bench: avalon host and eeprom slave joined by spd_i2c_if
// assumes the host register map and command bits of spd_pkg
`timescale 1ns/100ps
module spd_eeprom_serial_command_slave_tb;
	localparam int WC = 2000;
	localparam int S  = 1 << spd_pkg::CMD_START;
	localparam int W  = 1 << spd_pkg::CMD_WRITE;
	localparam int R  = 1 << spd_pkg::CMD_READ;
	localparam int P  = 1 << spd_pkg::CMD_STOP;
	localparam int N  = 1 << spd_pkg::CMD_NACK;
	logic        clk_sys = 1'b0;
	logic        rst;
	logic        read;
	logic        write;
	logic        hv;
	logic        nk;
	logic        waitrequest;
	logic        write_busy;
	logic [3:0]  address;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic [31:0] rnd;
	logic [2:0]  pins;
	logic [7:0]  a;
	logic [7:0]  d;
	logic [7:0]  mem [16];
	logic [2:0]  blk [4] = '{spd_pkg::SEL_BLK0, spd_pkg::SEL_BLK1, spd_pkg::SEL_BLK2,
		spd_pkg::SEL_BLK3};
	int          failures = 0;
	int          checks_done = 0;
	int          n;
	int          polls;
	wire  [7:0]  wsel = {spd_pkg::TYPE_MEM, pins, 1'b0};

	always #2.5 clk_sys = !clk_sys;

	spd_i2c_if link ();
	spd_i2c_host #(.QUARTER(8)) spd_i2c_host_inst (.clk_sys(clk_sys), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .link(link));
	spd_eeprom_slave #(.WRITE_CYCLES(WC)) spd_eeprom_slave_inst (.clk_sys(clk_sys), .rst(rst),
		.link(link), .select_pins(pins), .select_pin_0_hv(hv), .write_busy(write_busy));
	spd_eeprom_slave_properties #(.WRITE_CYCLES(WC)) spd_eeprom_slave_properties_inst (
		.clk_sys(clk_sys), .rst(rst), .scl(link.scl), .sda(link.sda),
		.sda_s_oe_n(link.sda_s_oe_n), .write_busy(write_busy));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] wd,
		output logic [31:0] q);
		@(posedge clk_sys);
		read <= !w;
		write <= w;
		address <= ad;
		writedata <= wd;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// one host command, then wait for it; leaves the ack flag and read byte
	task automatic op(input int c, input logic [7:0] tx);
		logic [31:0] q;
		if ((c & W) != 0) av(1'b1, spd_pkg::REG_TX, {24'h0, tx}, q);
		av(1'b1, spd_pkg::REG_CMD, 32'(c), q);
		do av(1'b0, spd_pkg::REG_STAT, 32'h0, q); while (q[spd_pkg::STAT_BUSY] !== 1'b0);
		nk = q[spd_pkg::STAT_NACK];
		if ((c & R) != 0) begin
			av(1'b0, spd_pkg::REG_RX, 32'h0, q);
			d = q[7:0];
		end
	endtask

	task automatic ready();
		polls = 0;
		do begin
			op(S | W, wsel);
			polls++;
		end while (nk === 1'b1 && polls < 200);
		op(P, 8'h00);
	endtask

	task automatic prot(input logic [2:0] code);
		op(S | W, {spd_pkg::TYPE_PROT, code, 1'b0});
		chk("protect select", nk, 0);
		op(W, 8'h00);
		op(W | P, 8'h00);
		ready();
	endtask

	task automatic status(input logic e);
		for (int k = 0; k < 4; k++) begin
			op(S | W, {spd_pkg::TYPE_PROT, blk[k], 1'b1});
			chk("status", nk, e);
			op(P, 8'h00);
		end
	endtask

	task automatic rd_at(input logic [7:0] ad);
		op(S | W, wsel);
		op(W, ad);
		op(S | W, wsel | 8'h01);
		op(R | N | P, 8'h00);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		// about 170 link operations of some 330 clocks each, with margin
		repeat (90000) @(posedge clk_sys);
		failures++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0000_0000;
		hv = 1'b0;
		rnd = lfsr(32'hfa3e_bad9);
		pins = rnd[2:0];
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rnd = lfsr(rnd);
		a = {1'b0, rnd[6:4], 4'h0};
		// a full 16-byte page is the corner case
		n = rnd[10] ? 16 : 2 + int'(rnd[9:8]);
		op(S | W, wsel);
		chk("mem select", nk, 0);
		op(W, a);
		chk("address", nk, 0);
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			mem[i] = rnd[7:0];
			op((i == n - 1) ? (W | P) : W, mem[i]);
			chk("data ack", nk, 0);
		end
		ready();
		chk("busy polls", 32'(polls > 1), 1);
		op(S | W, wsel);
		op(W | P, a);
		repeat (20) @(posedge clk_sys);
		chk("no write cycle", write_busy, 0);
		for (int i = 0; i < 2; i++) begin
			op(S | W, wsel | 8'h01);
			op(R | N | P, 8'h00);
			chk("current read", d, mem[i]);
		end
		op(S | W, wsel);
		op(W, a);
		op(S | W, wsel | 8'h01);
		chk("read select", nk, 0);
		for (int i = 0; i < n; i++) begin
			op((i == n - 1) ? (R | N | P) : R, 8'h00);
			chk("sequential", d, mem[i]);
		end
		op(S | W, {spd_pkg::TYPE_MEM, ~pins, 1'b0});
		chk("foreign select", nk, 1);
		op(P, 8'h00);
		op(S | W, {spd_pkg::TYPE_PROT, spd_pkg::SEL_BLK1, 1'b0});
		chk("set without hv", nk, 1);
		op(P, 8'h00);
		op(S | W, {spd_pkg::TYPE_PROT, 3'h2, 1'b0});
		chk("reserved", nk, 1);
		op(P, 8'h00);
		hv <= 1'b1;
		for (int k = 0; k < 4; k++) prot(blk[k]);
		hv <= 1'b0;
		status(1'b1);
		op(S | W, wsel);
		op(W, a);
		op(W | P, ~mem[0]);
		chk("protected byte", nk, 1);
		repeat (20) @(posedge clk_sys);
		chk("protected busy", write_busy, 0);
		op(S | W, wsel | 8'h01);
		op(R | N | P, 8'h00);
		chk("held counter", d, mem[0]);
		hv <= 1'b1;
		prot(spd_pkg::SEL_CLR);
		hv <= 1'b0;
		status(1'b0);
		op(S | W, {spd_pkg::TYPE_PROT, spd_pkg::SEL_SPA1, 1'b0});
		chk("upper page select", nk, 0);
		op(P, 8'h00);
		op(S | W, {spd_pkg::TYPE_PROT, spd_pkg::SEL_RPA, 1'b1});
		chk("page read one", nk, 1);
		op(P, 8'h00);
		rnd = lfsr(rnd);
		op(S | W, wsel);
		op(W, a);
		op(W | P, rnd[7:0]);
		ready();
		rd_at(a);
		chk("upper page data", d, rnd[7:0]);
		op(S | W, {spd_pkg::TYPE_PROT, spd_pkg::SEL_SPA0, 1'b0});
		op(P, 8'h00);
		rd_at(a);
		chk("lower page data", d, mem[0]);
		op(S | W, {spd_pkg::TYPE_PROT, spd_pkg::SEL_SPA1, 1'b0});
		op(P, 8'h00);
		rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (8) @(posedge clk_sys);
		op(S | W, {spd_pkg::TYPE_PROT, spd_pkg::SEL_RPA, 1'b1});
		chk("page after reset", nk, 0);
		op(P, 8'h00);
		test_done();
	end
endmodule
